// ===== src/ssr_sensor_ctrl.sv
// Sensor sample controller: device end of the request/response streams
`timescale 1ns/1ps
module ssr_sensor_ctrl
  import ssr_pkg::*;
#(
  parameter bit TEMP_VARIANT = 1'b0
) (
  input wire logic clk_sys_in,              // System clock, 125 MHz
  input wire logic rstn_in,                 // Synchronous reset, low
  ssr_stream_if.dev link,                   // Request/response streams
  output logic cm_rd_out,                   // Read pulse to config manager
  output logic [CHAN_W-1:0] cm_chan_out,    // Channel to read
  input wire logic cm_rd_done_in,           // Config manager answer pulse
  input wire logic [DATA_W-1:0] cm_rd_data_in, // Latest stored sample
  input wire logic cm_rd_err_in,            // Sample not available
  output logic busy_out                     // A request is in progress
);
  // Controller sequence
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_WAIT,
    ST_PUSH,
    ST_DRAIN
  } ssr_ctrl_e;

  // All controller state
  typedef struct packed {
    ssr_ctrl_e st;
    logic [MASK_W-1:0] pend;   // Channels still to read
    logic first;               // Next beat opens the packet
    logic [CHAN_W-1:0] chan;   // Channel being read
    ssr_beat_s beat;           // Beat waiting for buffer room
    logic cm_rd;
    logic cmd_ready;
    logic rsp_valid;
    ssr_beat_s rsp;            // Beat presented on the stream
    logic busy;
  } ssr_ctrl_s;

  // Mask bits that name real channels for this variant
  localparam logic [MASK_W-1:0] VOLT_VALID = VOLT_EXT_MASK | VOLT_INT_MASK;
  localparam logic [MASK_W-1:0] TEMP_VALID =
    TEMP_CORE_MASK | TEMP_XCVR_MASK | TEMP_STACK_MASK;
  localparam logic [MASK_W-1:0] VALID_MASK =
    TEMP_VARIANT ? TEMP_VALID : VOLT_VALID;

  ssr_ctrl_s s_reg;
  ssr_ctrl_s s_next;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  ssr_beat_s fifo_out_beat;
  logic [MASK_W-1:0] cmd_mask;
  logic [MASK_W-1:0] pend_left;

  // Bits outside the variant's channel set are dropped, so a stray bit
  // cannot produce a beat for a channel that does not exist
  assign cmd_mask = link.cmd_data & VALID_MASK;

  // Pending channels once the current one is done
  always_comb
  begin
    pend_left = s_reg.pend;
    pend_left[s_reg.chan] = 1'b0;
  end

  // Output stage refills whenever it is empty or being taken
  assign fifo_out_ready = !s_reg.rsp_valid || link.rsp_ready;

  // Beat buffer between the reads and the response stream; a slow
  // requester fills it and then stalls the reads in ST_PUSH
  ssr_fifo #(
    .WIDTH(BEAT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_beat_fifo (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in && link.ctrl_rstn),
    .in_valid_in(s_reg.st == ST_PUSH),
    .in_data_in(s_reg.beat),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_beat),
    .out_ready_in(fifo_out_ready)
  );

  // Next-state logic for the sequence and the output stage
  always_comb
  begin
    s_next = s_reg;
    s_next.cm_rd = 1'b0;
    unique case (s_reg.st)
      ST_IDLE:
      begin
        // Requests count only while ready is shown
        if (link.cmd_valid && s_reg.cmd_ready)
        begin
          if (cmd_mask == '0)
          begin
            // Nothing selected: no beats, stay ready
            s_next.cmd_ready = 1'b1;
          end
          else
          begin
            s_next.cmd_ready = 1'b0;
            s_next.pend = cmd_mask;
            s_next.first = 1'b1;
            s_next.st = ST_ISSUE;
          end
        end
      end
      ST_ISSUE:
      begin
        // Lowest pending channel first gives ascending order
        s_next.chan = ssr_low_chan(s_reg.pend);
        s_next.cm_rd = 1'b1;
        s_next.st = ST_WAIT;
      end
      ST_WAIT:
      begin
        // Answer may take any number of cycles; no timeout here,
        // the requester owns recovery by resetting the controller
        if (cm_rd_done_in)
        begin
          s_next.beat.sop = s_reg.first;
          s_next.beat.eop = (pend_left == '0);
          s_next.beat.chan = s_reg.chan;
          if (!cm_rd_err_in)
            s_next.beat.data = cm_rd_data_in;
          else if (TEMP_VARIANT)
            s_next.beat.data = TEMP_INVALID;
          else
            s_next.beat.data = VOLT_ERR_VALUE;
          s_next.pend = pend_left;
          s_next.first = 1'b0;
          s_next.st = ST_PUSH;
        end
      end
      ST_PUSH:
      begin
        // Hold the beat until the buffer has room
        if (fifo_in_ready)
          s_next.st = (s_reg.pend == '0) ? ST_DRAIN : ST_ISSUE;
      end
      ST_DRAIN:
      begin
        // Ready comes back only after the last beat is delivered
        if (s_reg.rsp_valid && link.rsp_ready && s_reg.rsp.eop)
        begin
          s_next.cmd_ready = 1'b1;
          s_next.st = ST_IDLE;
        end
      end
    endcase
    // Registered output stage keeps the stream outputs on flip-flops
    if (fifo_out_ready)
    begin
      s_next.rsp_valid = fifo_out_valid;
      s_next.rsp = fifo_out_beat;
    end
    s_next.busy = (s_next.st != ST_IDLE);
  end

  // State register; the requester's reset line also clears everything
  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in || !link.ctrl_rstn)
    begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.cmd_ready <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Stream and config manager outputs straight from state
  assign link.cmd_ready = s_reg.cmd_ready;
  assign link.rsp_valid = s_reg.rsp_valid;
  assign link.rsp_channel = s_reg.rsp.chan;
  assign link.rsp_data = s_reg.rsp.data;
  assign link.rsp_sop = s_reg.rsp.sop;
  assign link.rsp_eop = s_reg.rsp.eop;
  assign cm_rd_out = s_reg.cm_rd;
  assign cm_chan_out = s_reg.chan;
  assign busy_out = s_reg.busy;
endmodule : ssr_sensor_ctrl

// ===== src/ssr_pkg.sv
// Shared constants, types and helpers for the sensor sample requester
package ssr_pkg;
  // Stream widths and buffer depth
  localparam int MASK_W = 16;
  localparam int CHAN_W = 4;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 8;
  // Fixed-point fraction bits of each variant
  localparam int VOLT_FRAC_BITS = 16;
  localparam int TEMP_FRAC_BITS = 8;
  // Voltage mask: two external inputs, fourteen internal supplies
  localparam logic [MASK_W-1:0] VOLT_EXT_MASK = 16'h0003;
  localparam logic [MASK_W-1:0] VOLT_INT_MASK = 16'hFFFC;
  // Temperature mask: core, transceiver tiles, stacked memory
  localparam logic [MASK_W-1:0] TEMP_CORE_MASK = 16'h0001;
  localparam logic [MASK_W-1:0] TEMP_XCVR_MASK = 16'h007E;
  localparam logic [MASK_W-1:0] TEMP_STACK_MASK = 16'h0180;
  // Data words that flag an unusable temperature or voltage reading
  localparam logic [DATA_W-1:0] TEMP_INVALID = 32'h80000000;
  localparam logic [DATA_W-1:0] VOLT_ERR_VALUE = 32'h00000000;
  // Command valid may stand for this many cycles at most
  localparam logic [1:0] CMD_MAX_HOLD = 2'h3;
  // Cycles the requester holds the controller in reset
  localparam logic [3:0] RELEASE_CYC = 4'h4;
  // Clock and config manager refresh period
  localparam int CLK_PERIOD_PS = 8000;
  localparam int CM_REFRESH_US = 1000;
  localparam int REFRESH_CYC = CM_REFRESH_US * 1000000 / CLK_PERIOD_PS;
  localparam int RSP_TIMEOUT_DEF = 4 * REFRESH_CYC;

  // One response beat as it travels through the buffer
  typedef struct packed {
    logic sop;
    logic eop;
    logic [CHAN_W-1:0] chan;
    logic [DATA_W-1:0] data;
  } ssr_beat_s;
  localparam int BEAT_W = $bits(ssr_beat_s);

  // Lowest set bit of a mask, zero when the mask is empty
  function automatic logic [CHAN_W-1:0] ssr_low_chan(
    input logic [MASK_W-1:0] mask
  );
    logic [CHAN_W-1:0] idx;
    idx = '0;
    for (int i = MASK_W - 1; i >= 0; i--)
    begin
      if (mask[i])
        idx = CHAN_W'(i);
    end
    return idx;
  endfunction : ssr_low_chan
endpackage : ssr_pkg

// ===== src/ssr_stream_if.sv
// Command and response streams between requester and controller
`timescale 1ns/1ps
interface ssr_stream_if;
  import ssr_pkg::*;
  logic ctrl_rstn;              // Controller reset, low active
  logic cmd_valid;              // Sampling request valid
  logic [MASK_W-1:0] cmd_data;  // Channel mask
  logic cmd_ready;              // Controller can take a request
  logic rsp_valid;              // Response beat valid
  logic [CHAN_W-1:0] rsp_channel; // Source channel of beat
  logic [DATA_W-1:0] rsp_data;  // Fixed-point sample
  logic rsp_sop;                // First beat of a request
  logic rsp_eop;                // Last beat of a request
  logic rsp_ready;              // Requester can take a beat

  // Documented controller end
  modport dev (
    input ctrl_rstn, cmd_valid, cmd_data, rsp_ready,
    output cmd_ready, rsp_valid, rsp_channel, rsp_data, rsp_sop, rsp_eop
  );
  // User logic end
  modport req (
    output ctrl_rstn, cmd_valid, cmd_data, rsp_ready,
    input cmd_ready, rsp_valid, rsp_channel, rsp_data, rsp_sop, rsp_eop
  );
endinterface : ssr_stream_if

// ===== src/ssr_fifo.sv
// Parameterised valid/ready FIFO for response beats
`timescale 1ns/1ps
module ssr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_in,           // System clock
  input wire logic rstn_in,              // Synchronous reset, low
  input wire logic in_valid_in,          // Write side valid
  input wire logic [WIDTH-1:0] in_data_in, // Write data
  output logic in_ready_out,             // Room for a word
  output logic out_valid_out,            // A word is waiting
  output logic [WIDTH-1:0] out_data_out, // Oldest word
  input wire logic out_ready_in          // Reader takes the word
);
  localparam int AW = $clog2(DEPTH);

  // Whole FIFO state, storage included
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } ssr_fifo_s;

  ssr_fifo_s s_reg;
  ssr_fifo_s s_next;
  logic push;
  logic pop;

  // Flags come straight from the count so full and empty are exact
  assign in_ready_out = (s_reg.cnt != (AW + 1)'(DEPTH));
  assign out_valid_out = (s_reg.cnt != '0);
  assign out_data_out = s_reg.mem[s_reg.rd];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Pointer and count update; depth is a power of two so pointers wrap
  always_comb
  begin
    s_next = s_reg;
    if (push)
    begin
      s_next.mem[s_reg.wr] = in_data_in;
      s_next.wr = s_reg.wr + 1'b1;
    end
    if (pop)
      s_next.rd = s_reg.rd + 1'b1;
    if (push && !pop)
      s_next.cnt = s_reg.cnt + 1'b1;
    else if (pop && !push)
      s_next.cnt = s_reg.cnt - 1'b1;
  end

  // State register
  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end
endmodule : ssr_fifo

// ===== src/ssr_requester.sv
// Requester: user-side end that issues sampling requests
`timescale 1ns/1ps
module ssr_requester
  import ssr_pkg::*;
#(
  parameter int RSP_TIMEOUT_CYC = RSP_TIMEOUT_DEF
) (
  input wire logic clk_sys_in,              // System clock, 125 MHz
  input wire logic rstn_in,                 // Synchronous reset, low
  ssr_stream_if.req link,                   // Request/response streams
  input wire logic user_mode_in,            // Device has entered user mode
  input wire logic req_in,                  // Start a request
  input wire logic [MASK_W-1:0] req_mask_in, // Channels wanted
  output logic req_ready_out,               // Request may be started
  output logic sample_valid_out,            // Sample held for user
  output logic sample_sop_out,              // Sample opens the packet
  output logic sample_eop_out,              // Sample closes the packet
  output logic [CHAN_W-1:0] sample_chan_out, // Sample channel
  output logic [DATA_W-1:0] sample_data_out, // Sample value
  input wire logic sample_ready_in,         // User takes the sample
  output logic fail_out                     // Refused or timed out, pulse
);
  // Requester sequence
  typedef enum logic [1:0] {
    RQ_RESET,
    RQ_IDLE,
    RQ_SEND,
    RQ_WAIT
  } ssr_req_e;

  // All requester state
  typedef struct packed {
    ssr_req_e st;
    logic [3:0] rel_cnt;
    logic [1:0] hold;
    logic [31:0] tmo;
    logic ctrl_rstn;
    logic cmd_valid;
    logic [MASK_W-1:0] cmd_data;
    logic rsp_ready;
    logic req_ready;
    logic smp_valid;
    ssr_beat_s smp;
    logic fail;
  } ssr_req_s;

  ssr_req_s s_reg;
  ssr_req_s s_next;
  logic take;

  // Beat handshake; lines are looked at only with valid high
  assign take = link.rsp_valid && s_reg.rsp_ready;

  // Next-state logic
  always_comb
  begin
    s_next = s_reg;
    s_next.fail = 1'b0;
    if (sample_ready_in)
      s_next.smp_valid = 1'b0;
    unique case (s_reg.st)
      RQ_RESET:
      begin
        // Hold the controller in reset, then release on a clock edge
        s_next.ctrl_rstn = 1'b0;
        s_next.rel_cnt = s_reg.rel_cnt + 1'b1;
        if (s_reg.rel_cnt == RELEASE_CYC)
        begin
          s_next.ctrl_rstn = 1'b1;
          s_next.st = RQ_IDLE;
        end
      end
      RQ_IDLE:
      begin
        // Nothing leaves before user mode; request lines stay zero
        s_next.req_ready = user_mode_in;
        if (req_in && s_reg.req_ready && user_mode_in)
        begin
          s_next.cmd_valid = 1'b1;
          s_next.cmd_data = req_mask_in;
          s_next.hold = 2'h1;
          s_next.req_ready = 1'b0;
          s_next.st = RQ_SEND;
        end
      end
      RQ_SEND:
      begin
        if (link.cmd_ready)
        begin
          s_next.cmd_valid = 1'b0;
          s_next.cmd_data = '0;
          s_next.tmo = '0;
          s_next.st = RQ_WAIT;
        end
        else if (s_reg.hold == CMD_MAX_HOLD)
        begin
          // Never stretch valid past three cycles; give up instead
          s_next.cmd_valid = 1'b0;
          s_next.cmd_data = '0;
          s_next.fail = 1'b1;
          s_next.st = RQ_IDLE;
        end
        else
        begin
          s_next.hold = s_reg.hold + 1'b1;
        end
      end
      RQ_WAIT:
      begin
        // Time only the gap between beats while one could be taken; the
        // user's own stall must not look like a lost answer
        if (take || !s_reg.rsp_ready)
          s_next.tmo = '0;
        else
          s_next.tmo = s_reg.tmo + 1'b1;
        if (take)
        begin
          // Value and channel captured in the beat's own cycle
          s_next.smp = '{sop: link.rsp_sop, eop: link.rsp_eop,
                         chan: link.rsp_channel,
                         data: link.rsp_data};
          s_next.smp_valid = 1'b1;
          if (link.rsp_eop)
            s_next.st = RQ_IDLE;
        end
        else if (s_reg.tmo == 32'(RSP_TIMEOUT_CYC - 1))
        begin
          // Lost answer: reset the controller to resynchronise
          s_next.fail = 1'b1;
          s_next.rel_cnt = '0;
          s_next.st = RQ_RESET;
        end
      end
    endcase
    // One beat held at a time; the stall reaches the controller buffer
    s_next.rsp_ready = !s_next.smp_valid;
  end

  // State register
  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
    begin
      s_reg <= '0;
      s_reg.st <= RQ_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state
  assign link.ctrl_rstn = s_reg.ctrl_rstn;
  assign link.cmd_valid = s_reg.cmd_valid;
  assign link.cmd_data = s_reg.cmd_data;
  assign link.rsp_ready = s_reg.rsp_ready;
  assign req_ready_out = s_reg.req_ready;
  assign sample_valid_out = s_reg.smp_valid;
  assign sample_sop_out = s_reg.smp.sop;
  assign sample_eop_out = s_reg.smp.eop;
  assign sample_chan_out = s_reg.smp.chan;
  assign sample_data_out = s_reg.smp.data;
  assign fail_out = s_reg.fail;
endmodule : ssr_requester

// ===== verification/ssr_stream_chk.sv
// Protocol checker for the command and response streams
`timescale 1ns/1ps
module ssr_stream_chk
  import ssr_pkg::*;
(
  input wire logic clk_sys_in, // System clock
  input wire logic rstn_in, // Bench reset, low
  input wire logic ctrl_rstn, // Controller reset, low
  input wire logic cmd_valid, // Request valid
  input wire logic [MASK_W-1:0] cmd_data, // Channel mask
  input wire logic cmd_ready, // Controller can take a request
  input wire logic rsp_valid, // Beat valid
  input wire logic [CHAN_W-1:0] rsp_channel, // Beat channel
  input wire logic [DATA_W-1:0] rsp_data, // Beat value
  input wire logic rsp_sop, // First beat
  input wire logic rsp_eop, // Last beat
  input wire logic rsp_ready // Requester takes the beat
);
  logic [MASK_W-1:0] mask_reg; // Mask of the accepted request
  logic [CHAN_W-1:0] last_chan_reg; // Channel of the previous beat
  logic rsp_hs; // Beat handed over this cycle
  assign rsp_hs = rsp_valid && rsp_ready;

  // Keep the accepted mask so each beat can be judged against it
  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
    begin
      mask_reg <= '0;
      last_chan_reg <= '0;
    end
    else
    begin
      if (cmd_valid && cmd_ready)
        mask_reg <= cmd_data;
      if (rsp_hs)
        last_chan_reg <= rsp_channel;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  // Either reset empties the controller, so nothing is judged then
  default disable iff (!rstn_in || !ctrl_rstn);

  AST_CMD_HOLD_MAX: assert property (not (cmd_valid [*4]))
    else $error("request valid held over three cycles");
  AST_READY_DROP: assert property
    (cmd_valid && cmd_ready && cmd_data != '0 |=> !cmd_ready)
    else $error("ready still high after a request");
  AST_READY_HOLD: assert property
    (!cmd_ready && !(rsp_hs && rsp_eop) |=> !cmd_ready)
    else $error("ready rose before the last beat");
  AST_READY_BACK: assert property (rsp_hs && rsp_eop |=> cmd_ready)
    else $error("ready not back after the last beat");
  AST_IN_MASK: assert property (rsp_hs |-> mask_reg[rsp_channel])
    else $error("beat for a channel not asked for");
  AST_SOP_FIRST: assert property (rsp_hs |-> rsp_sop ==
    ((mask_reg & ((16'h0001 << rsp_channel) - 16'h0001)) == 16'h0000))
    else $error("start flag wrong");
  AST_EOP_LAST: assert property
    (rsp_hs |-> rsp_eop == ((mask_reg >> rsp_channel) == 16'h0001))
    else $error("end flag wrong");
  AST_ASCEND: assert property
    (rsp_hs && !rsp_sop |-> rsp_channel > last_chan_reg)
    else $error("channels out of order");
  AST_RSP_STALL: assert property (rsp_valid && !rsp_ready |=>
    rsp_valid && $stable(rsp_data) && $stable({rsp_channel, rsp_sop, rsp_eop}))
    else $error("beat changed while stalled");
  AST_IDLE_QUIET: assert property (cmd_ready |-> !rsp_valid)
    else $error("beat while idle");

  COV_SINGLE: cover property (rsp_hs && rsp_sop && rsp_eop);
  COV_STALL: cover property ((rsp_valid && !rsp_ready) [*3]);
  COV_TOP_CHAN: cover property (rsp_hs && rsp_eop && rsp_channel == 4'hF);
endmodule : ssr_stream_chk

// ===== verification/sensor_sample_requester_tb.sv
// Bench joining requester and controller through their stream link
`timescale 1ns/1ps
module sensor_sample_requester_tb;
  import ssr_pkg::*;
  localparam int TMO_CYC = 200; // Short response timeout for simulation
  localparam int CEIL_CYC = 20000; // Hang guard for the whole run
  logic clk_sys_in, rstn_in, user_mode_in, req_in, req_ready_out;
  logic [MASK_W-1:0] req_mask_in, err_mask;
  logic sample_valid_out, sample_sop_out, sample_eop_out;
  logic sample_ready_in, fail_out, busy_out;
  logic [CHAN_W-1:0] sample_chan_out, cm_chan_out, cm_ch;
  logic [DATA_W-1:0] sample_data_out, cm_rd_data_in;
  logic cm_rd_out, cm_rd_done_in, cm_rd_err_in;
  int bad_count, num_checks, cyc, fail_seen, stall_cnt, cm_dly;
  int rd_cnt; // Config manager reads seen
  bit cm_silent; // Config manager never answers
  ssr_beat_s got_beat;
  ssr_beat_s exp_q[$]; // Beats still owed to the user

  ssr_stream_if link_if ();
  ssr_sensor_ctrl #(.TEMP_VARIANT(1'b0)) u_ssr_sensor_ctrl (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .link(link_if.dev),
    .cm_rd_out(cm_rd_out), .cm_chan_out(cm_chan_out),
    .cm_rd_done_in(cm_rd_done_in), .cm_rd_data_in(cm_rd_data_in),
    .cm_rd_err_in(cm_rd_err_in), .busy_out(busy_out));
  ssr_requester #(.RSP_TIMEOUT_CYC(TMO_CYC)) u_ssr_requester (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .link(link_if.req),
    .user_mode_in(user_mode_in), .req_in(req_in),
    .req_mask_in(req_mask_in), .req_ready_out(req_ready_out),
    .sample_valid_out(sample_valid_out), .sample_sop_out(sample_sop_out),
    .sample_eop_out(sample_eop_out), .sample_chan_out(sample_chan_out),
    .sample_data_out(sample_data_out), .sample_ready_in(sample_ready_in),
    .fail_out(fail_out));
  ssr_stream_chk u_ssr_stream_chk (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .ctrl_rstn(link_if.ctrl_rstn), .cmd_valid(link_if.cmd_valid),
    .cmd_data(link_if.cmd_data), .cmd_ready(link_if.cmd_ready),
    .rsp_valid(link_if.rsp_valid), .rsp_channel(link_if.rsp_channel),
    .rsp_data(link_if.rsp_data), .rsp_sop(link_if.rsp_sop),
    .rsp_eop(link_if.rsp_eop), .rsp_ready(link_if.rsp_ready));

  // Sample value the stand-in config manager holds per channel
  function automatic logic [DATA_W-1:0] cm_val(input logic [CHAN_W-1:0] ch);
    return {12'h000, ch, 16'hC000};
  endfunction : cm_val

  task automatic check_eq(input logic [63:0] got, input logic [63:0] exp,
    input string msg);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask : check_eq

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // Queue the owed beats, raise one request, wait until all arrived
  task automatic request(input logic [MASK_W-1:0] mask, input bit want);
    ssr_beat_s b;
    bit first;
    int last;
    first = 1'b1;
    last = 0;
    for (int i = 0; i < MASK_W; i++)
      if (mask[i])
        last = i;
    while (req_ready_out !== 1'b1)
      @(posedge clk_sys_in);
    for (int i = 0; i < MASK_W; i++)
    begin
      if (mask[i] && want)
      begin
        b.sop = first;
        b.eop = (i == last);
        b.chan = CHAN_W'(i);
        b.data = err_mask[i] ? VOLT_ERR_VALUE : cm_val(CHAN_W'(i));
        exp_q.push_back(b);
        first = 1'b0;
      end
    end
    req_in <= 1'b1;
    req_mask_in <= mask;
    @(posedge clk_sys_in);
    req_in <= 1'b0;
    req_mask_in <= '0;
    while (exp_q.size() != 0)
      @(posedge clk_sys_in);
  endtask : request

  // Stall the user so the beat buffer fills and the reads stop: one beat
  // held by the requester, one on the output stage, eight buffered and
  // one waiting for room makes eleven reads; then let it all drain
  task automatic fifo_test;
    stall_cnt = 300;
    rd_cnt = 0;
    fork
      request(16'hFFFF, 1'b1);
    join_none
    repeat (150) @(posedge clk_sys_in);
    check_eq(64'(rd_cnt), 64'hB, "reads while stalled");
    check_eq(64'({busy_out, link_if.cmd_ready}), 64'h2, "stalled");
    while (exp_q.size() != 0)
      @(posedge clk_sys_in);
    repeat (2) @(posedge clk_sys_in);
    check_eq(64'({busy_out, link_if.cmd_ready}), 64'h1, "drained");
    check_eq(64'(link_if.rsp_valid), 64'h0, "beat left over");
  endtask : fifo_test

  initial
  begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  // User side: takes beats unless told to stall, watches every beat
  always @(posedge clk_sys_in)
  begin
    sample_ready_in <= (stall_cnt == 0);
    if (stall_cnt > 0)
      stall_cnt--;
    got_beat = {sample_sop_out, sample_eop_out, sample_chan_out,
      sample_data_out};
    if (rstn_in === 1'b1 && sample_valid_out === 1'b1 && sample_ready_in)
    begin
      if (exp_q.size() == 0)
        check_eq(64'h1, 64'h0, "extra beat");
      else
        check_eq(64'(got_beat), 64'(exp_q.pop_front()), "beat");
    end
    if (rstn_in === 1'b1 && user_mode_in === 1'b0)
      check_eq(64'({link_if.cmd_valid, link_if.cmd_data}), 64'h0, "early");
    if (fail_out === 1'b1)
      fail_seen++;
    if (cm_rd_out === 1'b1)
      rd_cnt++;
  end

  // Stand-in config manager; released data lines show the inverted sample as garbage
  always @(posedge clk_sys_in)
  begin
    if (cm_rd_out === 1'b1 && !cm_silent)
    begin
      cm_ch = cm_chan_out;
      repeat (cm_dly) @(posedge clk_sys_in);
      cm_rd_done_in <= 1'b1;
      cm_rd_data_in <= cm_val(cm_ch);
      cm_rd_err_in <= err_mask[cm_ch];
      @(posedge clk_sys_in);
      cm_rd_done_in <= 1'b0;
      cm_rd_data_in <= ~cm_val(cm_ch);
      cm_rd_err_in <= 1'b0;
    end
  end

  // Hang guard
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == CEIL_CYC)
    begin
      bad_count++;
      $display("[FAIL] %0t run did not finish", $time);
      final_report();
    end
  end

  initial
  begin
    rstn_in = 1'b0;
    user_mode_in = 1'b0;
    req_in = 1'b0;
    req_mask_in = '0;
    err_mask = '0;
    sample_ready_in = 1'b0;
    cm_rd_done_in = 1'b0;
    cm_rd_data_in = '0;
    cm_rd_err_in = 1'b0;
    cm_dly = 1;
    repeat (4) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    // User asks before user mode; the link must stay quiet
    req_in <= 1'b1;
    req_mask_in <= 16'h0001;
    repeat (20) @(posedge clk_sys_in);
    req_in <= 1'b0;
    req_mask_in <= '0;
    user_mode_in <= 1'b1;
    @(posedge clk_sys_in);
    request(16'h000B, 1'b1);
    request(16'h8000, 1'b1);
    cm_dly = 40;
    err_mask = 16'h0004;
    request(16'h0006, 1'b1);
    err_mask = '0;
    cm_dly = 1;
    stall_cnt = 60;
    request(16'hFFFF, 1'b1);
    // Silent config manager: requester gives up and resets the controller
    cm_silent = 1'b1;
    request(16'h0010, 1'b0);
    repeat (TMO_CYC + 50) @(posedge clk_sys_in);
    check_eq(64'(fail_seen), 64'h1, "timeout");
    cm_silent = 1'b0;
    request(16'h0021, 1'b1);
    fifo_test();
    repeat (4) @(posedge clk_sys_in);
    final_report();
  end
endmodule : sensor_sample_requester_tb
